// ### src/srr_readout.sv
// Purpose: Decodes framed readout requests and sends framed responses
// Assumes: Receiver and transmitter bytes are on i_clock; values are live
// Notes:   A request arriving while a response is built is dropped
`timescale 1ns/100ps
module srr_readout #(
  parameter int IDLE_TIMEOUT_CYC = srr_pkg::SRR_IDLE_TIMEOUT_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic [3:0] i_unit_tens,
  input wire logic [3:0] i_unit_ones,
  input wire logic signed [31:0] i_conv_result,
  input wire logic signed [31:0] i_freq_a,
  input wire logic signed [31:0] i_freq_b,
  input wire logic signed [31:0] i_out_mv,
  output logic [4:0] o_aux_sel,
  input wire logic signed [31:0] i_aux_value,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  output logic [7:0] o_tx_data,
  output logic o_pc_mode,
  output logic o_busy
);

  // ==========================================================================
  // Parameter check
  generate
    if (IDLE_TIMEOUT_CYC < 2) begin : g_bad_timeout
      $error("srr_readout IDLE_TIMEOUT_CYC must be at least two");
    end
  endgenerate

  // ==========================================================================
  // Reset release
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ==========================================================================
  // PC mode idle timer
  logic [31:0] idle_cnt_r;
  logic pc_mode_r;
  assign o_pc_mode = pc_mode_r;
  always_ff @(posedge i_clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pc_mode_r <= 1'b0;
      idle_cnt_r <= 32'h0000_0000;
    end else if (i_rx_valid) begin
      pc_mode_r <= 1'b1;
      idle_cnt_r <= 32'h0000_0000;
    end else if (pc_mode_r) begin
      if (idle_cnt_r == 32'(IDLE_TIMEOUT_CYC - 1)) begin
        pc_mode_r <= 1'b0;
      end else begin
        idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
      end
    end
  end

  // ==========================================================================
  // Request parser
  typedef enum logic [5:0] {
    P_WAIT = 6'b00_0001,
    P_ADH = 6'b00_0010,
    P_ADL = 6'b00_0100,
    P_CH = 6'b00_1000,
    P_CL = 6'b01_0000,
    P_ENQ = 6'b10_0000
  } srr_parse_t;
  typedef enum logic [2:0] {
    R_IDLE = 3'b001,
    R_CONV = 3'b010,
    R_SEND = 3'b100
  } srr_resp_t;
  srr_parse_t parse_r;
  srr_parse_t parse_nxt;
  srr_resp_t resp_r;
  logic addr_hi_ok_r;
  logic [7:0] code_hi_r;
  logic [7:0] code_lo_r;
  // Byte classification
  wire rx_eot = (i_rx_data == srr_pkg::SRR_CH_EOT);
  wire rx_enq = (i_rx_data == srr_pkg::SRR_CH_ENQ);
  wire rx_digit = (i_rx_data >= srr_pkg::SRR_CH_ZERO) &&
                  (i_rx_data <= srr_pkg::SRR_CH_NINE);
  wire rx_group = (i_rx_data == srr_pkg::SRR_CH_COLON) ||
                  (i_rx_data == srr_pkg::SRR_CH_SEMI);
  wire addr_hi_hit = rx_digit && (i_rx_data[3:0] == i_unit_tens);
  wire addr_lo_hit = rx_digit && (i_rx_data[3:0] == i_unit_ones);
  wire addr_ok = addr_hi_ok_r && addr_lo_hit;
  wire req_done = i_rx_valid && (parse_r == P_ENQ) && rx_enq;
  wire start = req_done && (resp_r == R_IDLE);
  // Next parser state; an opener always restarts the frame
  always_comb begin
    parse_nxt = parse_r;
    if (i_rx_valid) begin
      if (rx_eot) begin
        parse_nxt = P_ADH;
      end else begin
        unique case (parse_r)
          P_WAIT: parse_nxt = P_WAIT;
          P_ADH: parse_nxt = P_ADL;
          P_ADL: parse_nxt = addr_ok ? P_CH : P_WAIT;
          P_CH: parse_nxt = rx_group ? P_CL : P_WAIT;
          P_CL: parse_nxt = rx_digit ? P_ENQ : P_WAIT;
          P_ENQ: parse_nxt = P_WAIT;
          default: parse_nxt = P_WAIT;
        endcase
      end
    end
  end

  // Parser registers
  always_ff @(posedge i_clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      parse_r <= P_WAIT;
      addr_hi_ok_r <= 1'b0;
      code_hi_r <= 8'h00;
      code_lo_r <= 8'h00;
    end else begin
      parse_r <= parse_nxt;
      if (i_rx_valid && parse_r == P_ADH) begin
        addr_hi_ok_r <= addr_hi_hit;
      end
      if (i_rx_valid && parse_r == P_CH && resp_r == R_IDLE) begin
        code_hi_r <= i_rx_data;
      end
      if (i_rx_valid && parse_r == P_CL && resp_r == R_IDLE) begin
        code_lo_r <= i_rx_data;
      end
    end
  end

  // ==========================================================================
  // Value selection by code index
  wire [4:0] code_idx = ((code_hi_r == srr_pkg::SRR_CH_SEMI) ?
                         srr_pkg::SRR_CODE_SEMI_BASE : 5'h00) +
                        {1'b0, code_lo_r[3:0]};
  assign o_aux_sel = code_idx;
  wire signed [31:0] value_sel =
    (code_idx == srr_pkg::SRR_CODE_CONV) ? i_conv_result :
    (code_idx == srr_pkg::SRR_CODE_FREQ_A) ? i_freq_a :
    (code_idx == srr_pkg::SRR_CODE_FREQ_B) ? i_freq_b :
    (code_idx == srr_pkg::SRR_CODE_VOLT) ? i_out_mv :
    i_aux_value;
  wire value_neg = value_sel[31];
  wire [31:0] value_abs = value_neg ? 32'(-value_sel) : 32'(value_sel);
  wire [23:0] value_mag = (value_abs > {8'h00, srr_pkg::SRR_MAG_MAX}) ?
                          srr_pkg::SRR_MAG_MAX : value_abs[23:0];

  // ==========================================================================
  // Response builder: decimal conversion then character output
  logic [23:0] rem_r;
  logic [2:0] dig_idx_r;
  logic [3:0] digits_r [srr_pkg::SRR_NUM_DIGITS];
  logic [3:0] char_idx_r;
  logic [7:0] bcc_r;
  logic sign_neg_r;
  logic [23:0] pow_ten;
  logic [7:0] char_out;
  logic buf_ready;
  // Power of ten for the digit being worked on, most significant first
  always_comb begin
    unique case (dig_idx_r)
      3'h0: pow_ten = 24'h0F_4240;
      3'h1: pow_ten = 24'h01_86A0;
      3'h2: pow_ten = 24'h00_2710;
      3'h3: pow_ten = 24'h00_03E8;
      3'h4: pow_ten = 24'h00_0064;
      3'h5: pow_ten = 24'h00_000A;
      default: pow_ten = 24'h00_0001; // Units digit
    endcase
  end

  // Character for the current response slot
  wire [3:0] dig_slot = char_idx_r - 4'h4;
  wire [7:0] dig_char = srr_pkg::SRR_CH_ZERO | {4'h0, digits_r[dig_slot[2:0]]};
  always_comb begin
    if (char_idx_r == 4'h0) begin
      char_out = srr_pkg::SRR_CH_STX;
    end else if (char_idx_r == 4'h1) begin
      char_out = code_hi_r;
    end else if (char_idx_r == 4'h2) begin
      char_out = code_lo_r;
    end else if (char_idx_r == srr_pkg::SRR_IDX_SIGN) begin
      char_out = sign_neg_r ? srr_pkg::SRR_CH_MINUS : srr_pkg::SRR_CH_PLUS;
    end else if (char_idx_r == srr_pkg::SRR_IDX_ETX) begin
      char_out = srr_pkg::SRR_CH_ETX;
    end else if (char_idx_r == srr_pkg::SRR_IDX_BCC) begin
      char_out = bcc_r;
    end else begin
      char_out = dig_char;
    end
  end

  wire sending = (resp_r == R_SEND);
  wire push = sending && buf_ready;
  wire rem_ge = (rem_r >= pow_ten);
  assign o_busy = (resp_r != R_IDLE);
  // Builder state and counters
  always_ff @(posedge i_clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      resp_r <= R_IDLE;
      rem_r <= 24'h00_0000;
      dig_idx_r <= 3'h0;
      char_idx_r <= 4'h0;
      sign_neg_r <= 1'b0;
      bcc_r <= 8'h00;
    end else begin
      unique case (resp_r)
        R_IDLE: if (start) begin
          resp_r <= R_CONV;
          rem_r <= value_mag;
          sign_neg_r <= value_neg;
          dig_idx_r <= 3'h0;
          char_idx_r <= 4'h0;
          bcc_r <= 8'h00;
        end
        R_CONV: if (rem_ge) begin
          rem_r <= rem_r - pow_ten;
        end else if (dig_idx_r == 3'(srr_pkg::SRR_NUM_DIGITS - 1)) begin
          resp_r <= R_SEND;
        end else begin
          dig_idx_r <= dig_idx_r + 3'h1;
        end
        R_SEND: if (push) begin
          if (char_idx_r != 4'h0 && char_idx_r != srr_pkg::SRR_IDX_BCC) begin
            bcc_r <= bcc_r ^ char_out;
          end
          if (char_idx_r == srr_pkg::SRR_IDX_BCC) begin
            resp_r <= R_IDLE;
          end else begin
            char_idx_r <= char_idx_r + 4'h1;
          end
        end
        default: resp_r <= R_IDLE;
      endcase
    end
  end

  // Decimal digits, counted up by repeated subtraction
  always_ff @(posedge i_clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      for (int k = 0; k < srr_pkg::SRR_NUM_DIGITS; k++) begin
        digits_r[k] <= 4'h0;
      end
    end else if (start) begin
      for (int k = 0; k < srr_pkg::SRR_NUM_DIGITS; k++) begin
        digits_r[k] <= 4'h0;
      end
    end else if (resp_r == R_CONV && rem_ge) begin
      digits_r[dig_idx_r] <= digits_r[dig_idx_r] + 4'h1;
    end
  end

  // ==========================================================================
  // Output buffer: a stalled transmitter holds the builder
  srr_buf2 #(
    .WIDTH(8)
  ) u_tx_buf (
    .i_clock(i_clock),
    .i_rst_n(rst_sync_r),
    .i_in_valid(sending),
    .o_in_ready(buf_ready),
    .i_in_data(char_out),
    .o_out_valid(o_tx_valid),
    .i_out_ready(i_tx_ready),
    .o_out_data(o_tx_data)
  );

endmodule : srr_readout

// ### src/srr_pkg.sv
// Purpose: Shared constants of the serial register readout block
// Assumes: Characters are 8-bit ASCII codes from a byte-wide receiver
// Notes:   Clock rate and idle timeout give the cycle count used in PC mode
package srr_pkg;

  // ==========================================================================
  // Framing characters
  localparam logic [7:0] SRR_CH_EOT = 8'h04;
  localparam logic [7:0] SRR_CH_ENQ = 8'h05;
  localparam logic [7:0] SRR_CH_STX = 8'h02;
  localparam logic [7:0] SRR_CH_ETX = 8'h03;
  localparam logic [7:0] SRR_CH_ZERO = 8'h30;
  localparam logic [7:0] SRR_CH_NINE = 8'h39;
  localparam logic [7:0] SRR_CH_COLON = 8'h3A;
  localparam logic [7:0] SRR_CH_SEMI = 8'h3B;
  localparam logic [7:0] SRR_CH_PLUS = 8'h2B;
  localparam logic [7:0] SRR_CH_MINUS = 8'h2D;

  // ==========================================================================
  // Code indices: colon group 0..9, semicolon group 10..19
  localparam logic [4:0] SRR_CODE_CONV = 5'h08;
  localparam logic [4:0] SRR_CODE_FREQ_A = 5'h09;
  localparam logic [4:0] SRR_CODE_FREQ_B = 5'h0B;
  localparam logic [4:0] SRR_CODE_VOLT = 5'h0D;
  localparam logic [4:0] SRR_CODE_SEMI_BASE = 5'h0A;

  // ==========================================================================
  // Response layout: STX, two code chars, sign, digits, ETX, check char
  localparam int SRR_NUM_DIGITS = 7;
  localparam logic [3:0] SRR_IDX_SIGN = 4'h3;
  localparam logic [3:0] SRR_IDX_ETX = 4'hB;
  localparam logic [3:0] SRR_IDX_BCC = 4'hC;
  localparam logic [23:0] SRR_MAG_MAX = 24'h98_967F;

  // ==========================================================================
  // Timing
  localparam int SRR_CLOCK_HZ = 20_000_000;
  localparam int SRR_IDLE_TIMEOUT_S = 20;
  localparam int SRR_IDLE_TIMEOUT_CYC = SRR_CLOCK_HZ * SRR_IDLE_TIMEOUT_S;

endpackage : srr_pkg

// ### src/srr_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, reset already synchronised
// Notes:   Head entry drives the output data straight from a flip-flop
`timescale 1ns/100ps
module srr_buf2 #(
  parameter int WIDTH = 8
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  // ==========================================================================
  // Parameter check
  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("srr_buf2 WIDTH must be at least one");
    end
  endgenerate

  logic [WIDTH-1:0] head_r;
  logic [WIDTH-1:0] tail_r;
  logic [1:0] count_r;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  // Handshake flags from the fill count
  assign o_in_ready = (count_r != 2'h2);
  assign o_out_valid = (count_r != 2'h0);
  assign o_out_data = head_r;

  // Fill count
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_r <= 2'h0;
    end else if (push && !pop) begin
      count_r <= count_r + 2'h1;
    end else if (pop && !push) begin
      count_r <= count_r - 2'h1;
    end
  end

  // Entries: the tail moves up into the head as words leave
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      head_r <= '0;
      tail_r <= '0;
    end else begin
      if ((push && count_r == 2'h0) || (push && pop && count_r == 2'h1)) begin
        head_r <= i_in_data;
      end else if (pop) begin
        head_r <= tail_r;
      end
      if (push && (count_r == 2'h2 - {1'b0, pop} || count_r == 2'h1)) begin
        tail_r <= i_in_data;
      end
    end
  end

endmodule : srr_buf2

// ### tb/srr_readout_props.sv
// Purpose: Port checker for the readout block
// Assumes: Bound into srr_readout
// Notes: Tx bytes are indexed modulo the 13 byte response
`timescale 1ns/100ps
module srr_readout_props #(
  parameter int IDLE_TIMEOUT_CYC = srr_pkg::SRR_IDLE_TIMEOUT_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic o_tx_valid,
  input wire logic i_tx_ready,
  input wire logic [7:0] o_tx_data,
  input wire logic o_pc_mode,
  input wire logic o_busy
);
  // ====
  // Byte position, running check char and idle count
  logic [3:0] idx_r;
  logic [7:0] bcc_r;
  int idle_r;
  wire tk = o_tx_valid && i_tx_ready;
  wire dig = o_tx_data inside {[8'h30:8'h39]};
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_r <= 4'h0;
      bcc_r <= 8'h00;
      idle_r <= 0;
    end else begin
      idle_r <= i_rx_valid ? 0 : idle_r + 1;
      if (tk) begin
        idx_r <= (idx_r == 4'hC) ? 4'h0 : idx_r + 4'h1;
        bcc_r <= (idx_r == 4'h0) ? 8'h00 : bcc_r ^ o_tx_data;
      end
    end
  end
  // ====
  // Properties
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  property p_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("byte lost in stall");
  property p_start; tk && idx_r == 4'h0 |-> o_tx_data == 8'h02;
  endproperty
  a_start: assert property (p_start) else $error("bad start char");
  property p_grp; tk && idx_r == 4'h1 |-> o_tx_data inside {8'h3A, 8'h3B};
  endproperty
  a_grp: assert property (p_grp) else $error("bad code group");
  property p_dig; tk && idx_r inside {4'h2, [4'h4:4'hA]} |-> dig;
  endproperty
  a_dig: assert property (p_dig) else $error("non digit char");
  property p_sign; tk && idx_r == 4'h3 |-> o_tx_data inside {8'h2B, 8'h2D};
  endproperty
  a_sign: assert property (p_sign) else $error("bad sign char");
  property p_end; tk && idx_r == 4'hB |-> o_tx_data == 8'h03;
  endproperty
  a_end: assert property (p_end) else $error("bad end char");
  property p_bcc; tk && idx_r == 4'hC |-> o_tx_data == bcc_r;
  endproperty
  a_bcc: assert property (p_bcc) else $error("bad check char");
  property p_ans;
    $rose(o_busy) |-> $past(i_rx_valid) && $past(i_rx_data) == 8'h05;
  endproperty
  a_ans: assert property (p_ans) else $error("answer without closer");
  property p_pc_on; i_rx_valid |=> o_pc_mode;
  endproperty
  a_pc_on: assert property (p_pc_on) else $error("mode not entered");
  property p_pc_off;
    $fell(o_pc_mode) |-> idle_r == IDLE_TIMEOUT_CYC;
  endproperty
  a_pc_off: assert property (p_pc_off) else $error("mode left early");
  c_resp: cover property (tk && idx_r == 4'hC);
  c_stall: cover property (o_tx_valid && !i_tx_ready);
  c_idle: cover property ($fell(o_pc_mode));
endmodule : srr_readout_props
bind srr_readout srr_readout_props #(.IDLE_TIMEOUT_CYC(IDLE_TIMEOUT_CYC))
  i_props (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_rx_valid(i_rx_valid),
  .i_rx_data(i_rx_data), .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready),
  .o_tx_data(o_tx_data), .o_pc_mode(o_pc_mode), .o_busy(o_busy));

// ### tb/srr_host_model.sv
// Purpose: Host that sends request strings and takes response bytes
// Assumes: Changes its lines at the falling edge
// Notes: Rx data shows the inverse of the last byte between frames
`timescale 1ns/100ps
module srr_host_model (
  input wire logic i_clock,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_tx_ready,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data
);
  logic [7:0] got_q[$];
  logic stall = 1'b0;
  logic [1:0] cnt_r = 2'h0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_tx_ready = 1'b1;
  end
  // Ready one cycle in four while stalling
  always @(negedge i_clock) begin
    cnt_r <= cnt_r + 2'h1;
    o_tx_ready <= !stall || cnt_r == 2'h0;
  end
  // Capture each byte taken from the device
  always @(posedge i_clock) begin
    if (o_tx_ready && i_tx_valid) got_q.push_back(i_tx_data);
  end
  // Bytes go back to back in the order given
  task automatic send(input logic [7:0] f[$]);
    foreach (f[k]) begin
      @(negedge i_clock);
      o_rx_valid = 1'b1;
      o_rx_data = f[k];
    end
    @(negedge i_clock);
    o_rx_valid = 1'b0;
    o_rx_data = ~o_rx_data;
  endtask : send
endmodule : srr_host_model

// ### tb/srr_readout_tb_top.sv
// Purpose: Self-checking bench for the readout block
// Assumes: Inputs change at the falling edge
// Notes: Short idle timeout keeps the run brief
`timescale 1ns/100ps
module srr_readout_tb_top;
  localparam int IDLE = 200;
  logic clock = 1'b0;
  logic rst_n, rx_valid, tx_valid, tx_ready, pc_mode, busy;
  logic [7:0] rx_data, tx_data;
  logic [3:0] tens, ones;
  logic [4:0] sel;
  logic signed [31:0] conv, fa, fb, mv, aux;
  logic signed [31:0] aux_tab[32];
  logic [7:0] exp_q[$];
  logic [31:0] rng = 32'h0000_0023;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  wire [7:0] ah = {4'h3, tens};
  wire [7:0] al = {4'h3, ones};
  assign aux = aux_tab[sel];
  srr_readout #(.IDLE_TIMEOUT_CYC(IDLE)) i_dut (
    .i_clock(clock), .i_rst_n(rst_n), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .i_unit_tens(tens), .i_unit_ones(ones),
    .i_conv_result(conv), .i_freq_a(fa), .i_freq_b(fb), .i_out_mv(mv),
    .o_aux_sel(sel), .i_aux_value(aux), .o_tx_valid(tx_valid),
    .i_tx_ready(tx_ready), .o_tx_data(tx_data), .o_pc_mode(pc_mode),
    .o_busy(busy));
  srr_host_model i_host (.i_clock(clock), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .o_tx_ready(tx_ready), .i_tx_valid(tx_valid),
    .i_tx_data(tx_data));
  initial begin
    forever #25 clock = ~clock;
  end
  // Cycle ceiling cuts a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  // ====
  // Helpers
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs
  task automatic check_val(input string what, input logic [31:0] e, s);
    n_tests++;
    if (e !== s) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask : check_val
  // Reference answer: 02, code, sign, 7 digits, 03, check char
  task automatic expect_resp(input logic [7:0] c1, c2);
    int i, v, m;
    logic [7:0] x;
    i = (c1 == 8'h3B ? 10 : 0) + int'(c2) - 48;
    v = (i == 8) ? conv : (i == 9) ? fa : (i == 11) ? fb :
      (i == 13) ? mv : aux_tab[i];
    m = (v < 0) ? -v : v;
    if (m > 9999999) m = 9999999;
    exp_q = '{8'h02, c1, c2, (v < 0) ? 8'h2D : 8'h2B};
    for (int k = 1000000; k > 0; k /= 10)
      exp_q.push_back(8'h30 + 8'(m / k % 10));
    exp_q.push_back(8'h03);
    x = 8'h00;
    for (int k = 1; k < exp_q.size(); k++) x ^= exp_q[k];
    exp_q.push_back(x);
  endtask : expect_resp
  // Send a frame, wait for the answer, compare every byte
  task automatic req(input logic [7:0] f[$], input bit ans);
    int n;
    exp_q.delete();
    if (ans) expect_resp(f[f.size() - 3], f[f.size() - 2]);
    i_host.got_q.delete();
    i_host.send(f);
    check_val("busy", 32'(ans), busy);
    repeat (100) @(posedge clock);
    for (n = 0; n < 900 && i_host.got_q.size() < exp_q.size(); n++)
      @(posedge clock);
    repeat (150) @(posedge clock);
    check_val("busy", 32'h0, busy);
    check_val("byte count", exp_q.size(), i_host.got_q.size());
    foreach (exp_q[k])
      if (k < i_host.got_q.size())
        check_val("tx byte", exp_q[k], i_host.got_q[k]);
  endtask : req
  task automatic rd(input logic [7:0] c1, c2);
    req('{8'h04, {4'h3, tens}, {4'h3, ones}, c1, c2, 8'h05}, 1);
  endtask : rd
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  // ====
  // Main sequence
  initial begin
    logic [7:0] c1, c2;
    rst_n = 1'b0;
    tens = 4'h1;
    ones = 4'h1;
    {conv, fa, fb, mv} = '0;
    foreach (aux_tab[k]) aux_tab[k] = $signed(xs()) >>> 8;
    repeat (6) @(posedge clock);
    @(negedge clock) rst_n = 1'b1;
    repeat (5) @(posedge clock);
    check_val("pc mode", 32'h0, pc_mode);
    // Every code with fresh values and unit number; odd codes stall
    for (int k = 0; k < 20; k++) begin
      @(negedge clock);
      tens = 4'(xs() % 10);
      ones = 4'(xs() % 10);
      conv = $signed(xs()) >>> (k + 4);
      fa = $signed(xs()) >>> (k + 4);
      fb = $signed(xs()) >>> (k + 4);
      mv = $signed(xs()) >>> (k + 4);
      i_host.stall = k[0];
      c1 = 8'h3A + 8'(k / 10);
      c2 = 8'h30 + 8'(k % 10);
      rd(c1, c2);
    end
    // Refused frames: other unit, bad code chars, missing closer
    i_host.stall = 1'b0;
    req('{8'h04, ah, al ^ 8'h01, 8'h3A, 8'h39, 8'h05}, 0);
    req('{8'h04, ah ^ 8'h02, al, 8'h3A, 8'h39, 8'h05}, 0);
    req('{8'h04, ah, al, 8'h3C, 8'h39, 8'h05}, 0);
    req('{8'h04, ah, al, 8'h3A, 8'h3A, 8'h05}, 0);
    req('{8'h04, ah, al, 8'h3A, 8'h39, 8'h39}, 0);
    // Opener restarts a frame; a second frame while busy is dropped
    req('{8'h04, ah, 8'h04, ah, al, 8'h3B, 8'h33, 8'h05}, 1);
    req('{8'h04, ah, al, 8'h3A, 8'h38, 8'h05, 8'h04, ah, al, 8'h3A,
      8'h38, 8'h05}, 1);
    // Mode flag follows a received byte and a quiet spell
    i_host.send('{8'h30});
    repeat (2) @(posedge clock);
    check_val("pc mode", 32'h1, pc_mode);
    repeat (IDLE - 20) @(posedge clock);
    check_val("pc mode", 32'h1, pc_mode);
    repeat (40) @(posedge clock);
    check_val("pc mode", 32'h0, pc_mode);
    final_report();
  end
endmodule : srr_readout_tb_top
